// file: rtl/lfc_pkg.sv
// Shared constants and types for the frame control and payload buffer block
package lfc_pkg;

    // ------------------------------------------------------------------
    // Geometry
    // ------------------------------------------------------------------
    localparam int unsigned LFC_DW     = 8;        // Register and byte width
    localparam int unsigned LFC_BYTES  = 8;        // Payload bytes per frame
    localparam int unsigned LFC_SEL_W  = 3;        // Payload byte select width
    localparam int unsigned LFC_ERR_W  = 5;        // Implemented error flags

    // ------------------------------------------------------------------
    // Indirect register indices
    // ------------------------------------------------------------------
    localparam logic [7:0] LFC_OFS_DATA_FIRST = 8'h00;  // First payload byte
    localparam logic [7:0] LFC_OFS_DATA_LAST  = 8'h07;  // Last payload byte
    localparam logic [7:0] LFC_OFS_CTRL       = 8'h08;  // Frame control
    localparam logic [7:0] LFC_OFS_STAT       = 8'h09;  // Link status
    localparam logic [7:0] LFC_OFS_ERR        = 8'h0A;  // Link error

    // ------------------------------------------------------------------
    // Frame control bit positions
    // ------------------------------------------------------------------
    localparam int unsigned LFC_CTL_HALT  = 7;     // Slave only, write trigger
    localparam int unsigned LFC_CTL_SLEEP = 6;     // Slave only
    localparam int unsigned LFC_CTL_DIR   = 5;     // Both roles
    localparam int unsigned LFC_CTL_ACK   = 4;     // Slave only, self clearing
    localparam int unsigned LFC_CTL_ICLR  = 3;     // Write trigger
    localparam int unsigned LFC_CTL_ECLR  = 2;     // Write trigger
    localparam int unsigned LFC_CTL_WAKE  = 1;     // Self clearing
    localparam int unsigned LFC_CTL_START = 0;     // Master only

    // ------------------------------------------------------------------
    // Link status bit positions
    // ------------------------------------------------------------------
    localparam int unsigned LFC_ST_IRQ  = 3;
    localparam int unsigned LFC_ST_ERR  = 2;
    localparam int unsigned LFC_ST_WAKE = 1;
    localparam int unsigned LFC_ST_DONE = 0;
    localparam int unsigned LFC_ST_HI   = 4;       // Lowest live upper bit

    // ------------------------------------------------------------------
    // Reset and fill values
    // ------------------------------------------------------------------
    localparam logic [7:0] LFC_BYTE_RST = 8'h00;
    localparam logic [7:0] LFC_IDX_RST  = 8'h00;
    localparam logic [7:0] LFC_ZERO     = 8'h00;
    localparam logic [2:0] LFC_ERR_PAD  = 3'h0;    // Unused error bits 7:5

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        LFC_RUN   = 2'b00,
        LFC_HALT  = 2'b01,
        LFC_SLEEP = 2'b10
    } lfc_link_e;

    typedef struct packed {
        logic [LFC_BYTES-1:0][LFC_DW-1:0] payload;
        logic [LFC_DW-1:0]                index;
        logic [LFC_DW-1:0]                rdata;
        logic                             sleep_en;
        logic                             dir;
        logic                             ack;
        logic                             wake_cmd;
        logic                             start_req;
        logic                             done;
        lfc_link_e                        link;
    } lfc_state_s;

endpackage : lfc_pkg

// file: rtl/lfc_sticky.sv
// Sticky event flags with a common clear; a set in the clear cycle survives
`timescale 1ns/1ps
module lfc_sticky #(
    parameter int unsigned W = 1
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         rst,
    // Events and clear
    input  wire logic [W-1:0] set,
    input  wire logic         clr,
    // Flags
    output logic      [W-1:0] q
);

    typedef struct packed {
        logic [W-1:0] flags;
    } lfc_sticky_s;

    lfc_sticky_s state_reg;
    lfc_sticky_s state_next;

    // Clear first, then set, so a coincident event is never lost
    always_comb begin
        state_next = state_reg;
        if (clr) begin
            state_next.flags = '0;
        end
        state_next.flags = state_next.flags | set;
    end

    // State register
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign q = state_reg.flags;

endmodule // lfc_sticky

// file: rtl/lfc_top.sv
// Frame control register and payload buffer of a single-wire link controller
`timescale 1ns/1ps
module lfc_top
    import lfc_pkg::*;
(
    // Clock and reset
    input  wire logic                   SYS_CLK,
    input  wire logic                   SYS_RST,
    // Role selection
    input  wire logic                   MODE_MASTER,
    // Indirect index port
    input  wire logic                   IDX_WR,
    input  wire logic [LFC_DW-1:0]      IDX_WDATA,
    output logic      [LFC_DW-1:0]      IDX_RDATA,
    // Indirect window port
    input  wire logic                   DAT_WR,
    input  wire logic                   DAT_RD,
    input  wire logic [LFC_DW-1:0]      DAT_WDATA,
    output logic      [LFC_DW-1:0]      DAT_RDATA,
    // Frame engine events
    input  wire logic                   SYNCH_BREAK_SEEN,
    input  wire logic                   SLEEP_FRAME_SEEN,
    input  wire logic                   IDLE_TIMEOUT,
    input  wire logic                   WAKEUP_SEEN,
    input  wire logic                   FRAME_DONE,
    input  wire logic                   FRAME_ERROR,
    input  wire logic                   IRQ_EVENT,
    input  wire logic [LFC_ERR_W-1:0]   ERR_EVENTS,
    input  wire logic [LFC_DW-1:0]      ENG_STATUS,
    // Frame engine payload access
    input  wire logic                   ENG_BYTE_WE,
    input  wire logic [LFC_SEL_W-1:0]   ENG_BYTE_SEL,
    input  wire logic [LFC_DW-1:0]      ENG_BYTE_WDATA,
    output logic [LFC_BYTES*LFC_DW-1:0] ENG_PAYLOAD,
    // Frame engine commands
    output logic                        FRAME_DIR,
    output logic                        FRAME_START_REQ,
    output logic                        DATA_REQ_ACK,
    output logic                        WAKEUP_SEND,
    output logic                        HALTED,
    output logic                        SLEEPING,
    output logic                        IRQ_PENDING
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    lfc_state_s               state_reg;
    lfc_state_s               state_next;

    logic                     is_master;
    logic                     is_slave;
    logic                     ctrl_wr;
    logic                     irq_clr;
    logic                     err_clr;
    logic                     irq_q;
    logic [LFC_ERR_W-1:0]     err_q;
    logic [LFC_DW-1:0]        ctrl_view;
    logic [LFC_DW-1:0]        stat_view;
    logic [LFC_DW-1:0]        err_view;
    logic [LFC_DW-1:0]        read_mux;
    logic                     idx_is_data;
    logic [LFC_SEL_W-1:0]     idx_sel;

    // ------------------------------------------------------------------
    // Role and decode
    // ------------------------------------------------------------------

    assign is_master = MODE_MASTER;
    assign is_slave  = ~MODE_MASTER;

    assign ctrl_wr     = DAT_WR && (state_reg.index == LFC_OFS_CTRL);
    assign idx_is_data = (state_reg.index <= LFC_OFS_DATA_LAST);
    assign idx_sel     = state_reg.index[LFC_SEL_W-1:0];

    assign irq_clr = ctrl_wr && DAT_WDATA[LFC_CTL_ICLR];

    assign err_clr = ctrl_wr && DAT_WDATA[LFC_CTL_ECLR];

    // ------------------------------------------------------------------
    // Sticky flags
    // ------------------------------------------------------------------

    lfc_sticky #(
        .W   (1)
    ) u_irq_flag (
        .clk (SYS_CLK),
        .rst (SYS_RST),
        .set (IRQ_EVENT),
        .clr (irq_clr),
        .q   (irq_q)
    );

    lfc_sticky #(
        .W   (LFC_ERR_W)
    ) u_err_flags (
        .clk (SYS_CLK),
        .rst (SYS_RST),
        .set (ERR_EVENTS),
        .clr (err_clr),
        .q   (err_q)
    );

    // ------------------------------------------------------------------
    // Read views
    // ------------------------------------------------------------------

    // Control readback: role-gated bits show zero in the other role
    always_comb begin
        ctrl_view = LFC_ZERO;
        ctrl_view[LFC_CTL_HALT]  = 1'b0;
        ctrl_view[LFC_CTL_ICLR]  = 1'b0;
        ctrl_view[LFC_CTL_ECLR]  = 1'b0;
        ctrl_view[LFC_CTL_SLEEP] = state_reg.sleep_en && is_slave;
        ctrl_view[LFC_CTL_ACK]   = state_reg.ack && is_slave;
        ctrl_view[LFC_CTL_START] = state_reg.start_req && is_master;
        ctrl_view[LFC_CTL_DIR]   = state_reg.dir;
        ctrl_view[LFC_CTL_WAKE]  = state_reg.wake_cmd;
    end

    // Status: upper bits and wakeup come live from the engine
    always_comb begin
        stat_view = ENG_STATUS;
        stat_view[LFC_ST_IRQ]  = irq_q;
        stat_view[LFC_ST_ERR]  = |err_q;
        stat_view[LFC_ST_DONE] = state_reg.done;
    end

    // Error register, unused upper bits read zero
    assign err_view = {LFC_ERR_PAD, err_q};

    always_comb begin
        read_mux = LFC_ZERO;
        if (idx_is_data) begin
            read_mux = state_reg.payload[idx_sel];
        end else begin
            case (state_reg.index)
                LFC_OFS_CTRL: begin
                    read_mux = ctrl_view;
                end
                LFC_OFS_STAT: begin
                    read_mux = stat_view;
                end
                LFC_OFS_ERR: begin
                    read_mux = err_view;
                end
                default: begin
                    read_mux = LFC_ZERO;  // Other indices belong elsewhere
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------

    // Hardware events are applied first so a same-cycle write wins
    always_comb begin
        state_next = state_reg;

        state_next.ack      = 1'b0;
        state_next.wake_cmd = 1'b0;

        // Index port write
        if (IDX_WR) begin
            state_next.index = IDX_WDATA;
        end

        // Registered read data, one cycle after the strobe
        if (DAT_RD) begin
            state_next.rdata = read_mux;
        end

        // engine stores received bytes, not while halted
        if (ENG_BYTE_WE && (state_reg.link != LFC_HALT)) begin
            state_next.payload[ENG_BYTE_SEL] = ENG_BYTE_WDATA;
        end

        // completion or error ends the start request
        if (FRAME_DONE || FRAME_ERROR) begin
            state_next.start_req = 1'b0;
        end
        if (FRAME_DONE) begin
            state_next.done = 1'b1;
        end

        // Link state transitions driven by the bus
        case (state_reg.link)
            LFC_RUN: begin
                // sleep entry on sleep frame or idle timeout
                if (is_slave && state_reg.sleep_en &&
                    (SLEEP_FRAME_SEEN || IDLE_TIMEOUT)) begin
                    state_next.link = LFC_SLEEP;
                end
            end
            LFC_HALT: begin
                if (SYNCH_BREAK_SEEN) begin
                    state_next.link = LFC_RUN;
                end
            end
            LFC_SLEEP: begin
                // wake on wakeup when sleep bit is clear
                if (!state_reg.sleep_en && WAKEUP_SEEN) begin
                    state_next.link = LFC_RUN;
                end
            end
            default: begin
                state_next.link = LFC_RUN;
            end
        endcase

        // window write to a payload byte
        if (DAT_WR && idx_is_data) begin
            state_next.payload[idx_sel] = DAT_WDATA;
        end

        // Frame control write
        if (ctrl_wr) begin
            state_next.dir = DAT_WDATA[LFC_CTL_DIR];

            // slave-only bits ignored in master role
            if (is_slave) begin
                state_next.sleep_en = DAT_WDATA[LFC_CTL_SLEEP];
                if (DAT_WDATA[LFC_CTL_HALT]) begin
                    state_next.link = LFC_HALT;
                end
                if (DAT_WDATA[LFC_CTL_ACK]) begin
                    state_next.ack = 1'b1;
                end
            end

            if (is_master && DAT_WDATA[LFC_CTL_START]) begin
                state_next.start_req = 1'b1;
                state_next.done      = 1'b0;  // Done drops at frame start
            end

            if (DAT_WDATA[LFC_CTL_WAKE]) begin
                state_next.wake_cmd = 1'b1;
                if (state_reg.link == LFC_SLEEP) begin
                    state_next.link = LFC_RUN;
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------

    // Everything resets to zero; index points at the first payload byte
    always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            state_reg         <= '0;
            state_reg.payload <= {LFC_BYTES{LFC_BYTE_RST}};
            state_reg.index   <= LFC_IDX_RST;
            state_reg.link    <= LFC_RUN;
        end else begin
            state_reg <= state_next;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------

    // Outputs come straight from flip-flops, HALTED and SLEEPING via a decode of the link state
    assign IDX_RDATA   = state_reg.index;
    assign DAT_RDATA   = state_reg.rdata;
    assign ENG_PAYLOAD = state_reg.payload;

    assign FRAME_DIR       = state_reg.dir;
    // start level held until done or error
    assign FRAME_START_REQ = state_reg.start_req;
    assign DATA_REQ_ACK    = state_reg.ack;
    assign WAKEUP_SEND     = state_reg.wake_cmd;
    assign HALTED          = (state_reg.link == LFC_HALT);
    assign SLEEPING        = (state_reg.link == LFC_SLEEP);
    assign IRQ_PENDING     = irq_q;

endmodule // lfc_top

// file: verification/lfc_top_asserts.sv
// Port-level assertion checker for the frame control block
`timescale 1ns/1ps
module lfc_chk
    import lfc_pkg::*;
(
    // Clock and reset
    input logic              SYS_CLK,
    input logic              SYS_RST,
    // Software side
    input logic              MODE_MASTER,
    input logic              IDX_WR,
    input logic [LFC_DW-1:0] IDX_WDATA,
    input logic [LFC_DW-1:0] IDX_RDATA,
    input logic              DAT_WR,
    input logic [LFC_DW-1:0] DAT_WDATA,
    // Engine side
    input logic              SYNCH_BREAK_SEEN,
    input logic              FRAME_DONE,
    input logic              FRAME_ERROR,
    input logic              FRAME_DIR,
    input logic              FRAME_START_REQ,
    input logic              DATA_REQ_ACK,
    input logic              WAKEUP_SEND,
    input logic              HALTED,
    input logic              IRQ_PENDING
);
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (SYS_RST);

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    // Control writes decoded from the index held before the edge
    wire logic wc = DAT_WR && (IDX_RDATA == LFC_OFS_CTRL);
    wire logic ws = wc && !MODE_MASTER;
    wire logic wst = wc && MODE_MASTER && DAT_WDATA[LFC_CTL_START];
    wire logic whl = ws && DAT_WDATA[LFC_CTL_HALT];
    wire logic wwk = wc && DAT_WDATA[LFC_CTL_WAKE];

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    property p_idx; IDX_WR |=> IDX_RDATA == $past(IDX_WDATA); endproperty
    a_idx: assert property (p_idx) else $error("index not loaded");
    property p_start; wst |=> FRAME_START_REQ; endproperty
    a_start: assert property (p_start) else $error("start not set");
    property p_slv_start; ws && !FRAME_START_REQ |=> !FRAME_START_REQ; endproperty
    a_slv_start: assert property (p_slv_start) else $error("slave start");
    property p_end; (FRAME_DONE || FRAME_ERROR) && !wst |=> !FRAME_START_REQ; endproperty
    a_end: assert property (p_end) else $error("start not cleared");
    // Start must hold through the whole frame, a zero write does not cancel
    property p_hold; FRAME_START_REQ && !FRAME_DONE && !FRAME_ERROR |=> FRAME_START_REQ;
    endproperty
    a_hold: assert property (p_hold) else $error("start dropped");
    property p_dir; wc |=> FRAME_DIR == $past(DAT_WDATA[LFC_CTL_DIR]); endproperty
    a_dir: assert property (p_dir) else $error("direction wrong");
    property p_ack; wc && DAT_WDATA[LFC_CTL_ACK] |=> DATA_REQ_ACK == !$past(MODE_MASTER);
    endproperty
    a_ack: assert property (p_ack) else $error("ack wrong");
    property p_ack_end; DATA_REQ_ACK && !(ws && DAT_WDATA[LFC_CTL_ACK]) |=> !DATA_REQ_ACK;
    endproperty
    a_ack_end: assert property (p_ack_end) else $error("ack stuck");
    // A back-to-back wakeup write legally stretches the pulse
    property p_wake; wwk |=> WAKEUP_SEND ##1 (!WAKEUP_SEND || $past(wwk));
    endproperty
    a_wake: assert property (p_wake) else $error("wakeup pulse wrong");
    // A synch break right after the halt write may end it one cycle later
    property p_halt; whl && !SYNCH_BREAK_SEEN |=> HALTED ##1 (HALTED || $past(SYNCH_BREAK_SEEN));
    endproperty
    a_halt: assert property (p_halt) else $error("halt not held");
    property p_unhalt; HALTED && SYNCH_BREAK_SEEN && !whl |=> !HALTED; endproperty
    a_unhalt: assert property (p_unhalt) else $error("halt not left");
    property p_irq; IRQ_PENDING && !(wc && DAT_WDATA[LFC_CTL_ICLR]) |=> IRQ_PENDING;
    endproperty
    a_irq: assert property (p_irq) else $error("irq lost");

    // ------------------------------------------------------------------
    // Covers
    // ------------------------------------------------------------------
    c_frame: cover property ($fell(FRAME_START_REQ));
    c_halt: cover property (HALTED && SYNCH_BREAK_SEEN);
    c_ack: cover property (DATA_REQ_ACK);
endmodule // lfc_chk

// file: verification/lfc_node.sv
// Behavioural frame engine standing on the far side of the block
`timescale 1ns/1ps
module lfc_node (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst,
    // Commands and knobs
    input  wire logic       start_req,
    input  wire logic       dir,
    input  wire logic       slow,
    input  wire logic       fail,
    // Events to the block
    output logic            done,
    output logic            error,
    output logic            byte_we,
    output logic [2:0]      byte_sel,
    output logic [7:0]      byte_wdata
);
    logic [5:0] cnt;

    // frame run
    // Idle data toggles so a stale byte never looks like fresh data
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt        <= 6'h00;
            done       <= 1'b0;
            error      <= 1'b0;
            byte_we    <= 1'b0;
            byte_sel   <= 3'h0;
            byte_wdata <= 8'h00;
        end else begin
            done       <= 1'b0;
            error      <= 1'b0;
            byte_we    <= 1'b0;
            byte_wdata <= ~byte_wdata;
            if (start_req && !done && !error) begin
                cnt <= cnt + 6'h01;
                if (!dir && cnt < 6'h08) begin
                    byte_we    <= 1'b1;
                    byte_sel   <= cnt[2:0];
                    byte_wdata <= 8'hA0 + {2'h0, cnt};
                end
                if (cnt == (slow ? 6'h1E : 6'h09)) begin
                    cnt   <= 6'h00;
                    done  <= !fail;
                    error <= fail;
                end
            end
        end
    end
endmodule // lfc_node

// file: verification/tb.sv
// Self-checking bench for the frame control and payload buffer block
`timescale 1ns/1ps
module tb;
    import lfc_pkg::*;

    // ------------------------------------------------------------------
    // Signals and bench model
    // ------------------------------------------------------------------
    logic        clk, rst, mm, iwr, dwr, drd, slow, fail, done, ferr, bwe;
    logic        dir, sreq, ack, wake, halt, slp, irq;
    logic [7:0]  iwd, ird, dwd, rdq, es, bwd;
    logic [4:0]  ev, errv;
    logic [2:0]  bsel;
    logic [7:0]  pay [8];
    logic [63:0] pl;
    logic        m_dir, m_sleep, m_start, m_done, m_irq;
    logic [4:0]  m_err;
    int          err_total, comparisons, i;

    // Free-running system clock
    initial clk = 1'b0;
    always #4 clk = ~clk;

    lfc_top u_lfc_top (
        .SYS_CLK(clk), .SYS_RST(rst), .MODE_MASTER(mm),
        .IDX_WR(iwr), .IDX_WDATA(iwd), .IDX_RDATA(ird),
        .DAT_WR(dwr), .DAT_RD(drd), .DAT_WDATA(dwd), .DAT_RDATA(rdq),
        .SYNCH_BREAK_SEEN(ev[0]), .SLEEP_FRAME_SEEN(ev[1]), .IDLE_TIMEOUT(ev[2]),
        .WAKEUP_SEEN(ev[3]), .FRAME_DONE(done), .FRAME_ERROR(ferr), .IRQ_EVENT(ev[4]),
        .ERR_EVENTS(errv), .ENG_STATUS(es), .ENG_BYTE_WE(bwe), .ENG_BYTE_SEL(bsel),
        .ENG_BYTE_WDATA(bwd), .ENG_PAYLOAD(pl), .FRAME_DIR(dir), .FRAME_START_REQ(sreq),
        .DATA_REQ_ACK(ack), .WAKEUP_SEND(wake), .HALTED(halt), .SLEEPING(slp),
        .IRQ_PENDING(irq));

    lfc_node u_lfc_node (
        .clk(clk), .rst(rst), .start_req(sreq), .dir(dir), .slow(slow), .fail(fail),
        .done(done), .error(ferr), .byte_we(bwe), .byte_sel(bsel), .byte_wdata(bwd));

    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    task final_report;
        $display("comparisons %0d err_total %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // Index write, then one window strobe in the next cycle
    task automatic acc(input logic [7:0] a, input logic w, input logic [7:0] d);
        @(negedge clk);
        iwr = 1'b1;
        iwd = a;
        @(negedge clk);
        iwr = 1'b0;
        dwr = w;
        drd = !w;
        dwd = d;
        @(negedge clk);
        dwr = 1'b0;
        drd = 1'b0;
    endtask

    // Expected window contents from the bench model
    function automatic logic [7:0] exp_reg(input logic [7:0] a);
        if (a <= LFC_OFS_DATA_LAST) return pay[a[2:0]];
        if (a == LFC_OFS_CTRL) return {1'b0, m_sleep & ~mm, m_dir, 4'h0, m_start & mm};
        if (a == LFC_OFS_STAT) return {es[7:4], m_irq, |m_err, es[1], m_done};
        if (a == LFC_OFS_ERR) return {3'h0, m_err};
        return 8'h00;
    endfunction

    task automatic check_all;
        for (int a = 0; a < 13; a++) begin
            acc((a == 12) ? 8'hFF : a[7:0], 1'b0, 8'h00);
            chk(ird, (a == 12) ? 8'hFF : a[7:0]);
            chk(rdq, exp_reg((a == 12) ? 8'hFF : a[7:0]));
        end
        // Engine-facing copy of the buffer must match the model byte for byte
        foreach (pay[n]) chk(pl[n*8 +: 8], pay[n]);
    endtask

    task automatic ctl(input logic [7:0] d);
        acc(LFC_OFS_CTRL, 1'b1, d);
        m_dir = d[LFC_CTL_DIR];
        if (!mm) m_sleep = d[LFC_CTL_SLEEP];
        if (mm && d[LFC_CTL_START]) m_done = 1'b0;
        if (mm && d[LFC_CTL_START]) m_start = 1'b1;
        if (d[LFC_CTL_ICLR]) m_irq = 1'b0;
        if (d[LFC_CTL_ECLR]) m_err = 5'h00;
    endtask

    task automatic pulse(input logic [4:0] m, input logic [4:0] e);
        @(negedge clk);
        ev = m;
        errv = e;
        @(negedge clk);
        ev = 5'h00;
        errv = 5'h00;
    endtask

    // One master frame: start, wait bounded, then check everything
    task automatic frame(input logic d, input logic s, input logic f);
        slow = s;
        fail = f;
        ctl({2'b00, d, 5'h01});
        chk(sreq, 1'b1);
        chk(dir, d);
        for (i = 0; i < 200 && sreq === 1'b1; i++) @(negedge clk);
        if (i == 200) begin
            err_total++;
            final_report;
        end
        m_start = 1'b0;
        m_done = !f;
        if (!d) foreach (pay[n]) pay[n] = 8'hA0 + n[7:0];
        check_all;
    endtask

    task automatic do_reset;
        rst = 1'b1;
        repeat (5) @(negedge clk);
        rst = 1'b0;
        {m_dir, m_sleep, m_start, m_done, m_irq, m_err} = '0;
        foreach (pay[n]) pay[n] = 8'h00;
        chk({1'b0, halt, slp, irq, sreq, dir, ack, wake}, 8'h00);
    endtask

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        {iwr, dwr, drd, mm, slow, fail, ev, errv, iwd, dwd} = '0;
        err_total = 0;
        comparisons = 0;
        i = $urandom(27901);
        es = 8'($urandom);
        do_reset;
        check_all;
        foreach (pay[n]) begin
            pay[n] = 8'($urandom);
            acc(n[7:0], 1'b1, pay[n]);
        end
        acc(LFC_OFS_STAT, 1'b1, 8'hFF);
        check_all;
        mm = 1'b1;
        frame(1'b1, 1'b1, 1'b0);
        frame(1'b0, 1'b0, 1'b0);
        frame(1'b1, 1'b0, 1'b1);
        ctl(8'hD0);
        chk({halt, ack}, 2'b00);
        check_all;
        mm = 1'b0;
        ctl(8'h01);
        chk(sreq, 1'b0);
        ctl(8'h90);
        chk({ack, halt}, 2'b11);
        @(negedge clk);
        chk(ack, 1'b0);
        check_all;
        pulse(5'h01, 5'h00);
        chk(halt, 1'b0);
        ctl(8'h40);
        pulse(5'h02, 5'h00);
        chk(slp, 1'b1);
        ctl(8'h42);
        chk({wake, slp}, 2'b10);
        @(negedge clk);
        chk(wake, 1'b0);
        pulse(5'h04, 5'h00);
        chk(slp, 1'b1);
        ctl(8'h00);
        pulse(5'h08, 5'h00);
        chk(slp, 1'b0);
        m_err = 5'($urandom_range(31, 1));
        m_irq = 1'b1;
        pulse(5'h10, m_err);
        ctl(8'h20);
        check_all;
        ctl(8'h08);
        chk(irq, 1'b0);
        check_all;
        ctl(8'h04);
        check_all;
        do_reset;
        check_all;
        final_report;
    end
endmodule // tb

bind lfc_top lfc_chk u_lfc_chk (.SYS_CLK, .SYS_RST, .MODE_MASTER, .IDX_WR, .IDX_WDATA,
    .IDX_RDATA, .DAT_WR, .DAT_WDATA, .SYNCH_BREAK_SEEN, .FRAME_DONE, .FRAME_ERROR,
    .FRAME_DIR, .FRAME_START_REQ, .DATA_REQ_ACK, .WAKEUP_SEND, .HALTED, .IRQ_PENDING);
